/* File: hdl/alor_pkg.sv */
// package: register map, encodings and carrier types of the alarm/output block
package alor_pkg;
    // register word addresses on the parameter channel
    localparam logic [15:0] ADDR_LIM2_STATE = 16'h0144;
    localparam logic [15:0] ADDR_LIM3_STATE = 16'h0145;
    localparam logic [15:0] ADDR_HOURS_MSG = 16'h0146;
    localparam logic [15:0] ADDR_CYCLES_MSG = 16'h0147;
    localparam logic [15:0] ADDR_OUT_STATE = 16'h03ac;
    localparam logic [15:0] ADDR_SENSE = 16'h03cc;
    localparam logic [15:0] ADDR_LIM1_EN = 16'h03cd;
    localparam logic [15:0] ADDR_LIM2_EN = 16'h03ce;
    localparam logic [15:0] ADDR_LIM3_EN = 16'h03cf;
    // register data width
    localparam int DATA_W = 16;
    // three-state alarm encoding
    localparam logic [1:0] ALARM_NONE = 2'h0;
    localparam logic [1:0] ALARM_STORED = 2'h1;
    localparam logic [1:0] ALARM_ACTIVE = 2'h2;
    // value written to acknowledge
    localparam logic [15:0] ACK_VALUE = 16'h0000;
    // output sense encoding
    localparam logic SENSE_DIRECT = 1'b0;
    localparam logic SENSE_INVERSE = 1'b1;
    // reset values of settings
    localparam logic SENSE_RESET = 1'b0;
    localparam logic [2:0] ENABLE_RESET = 3'h0;
    // default maintenance presets
    localparam int HOURS_PRESET_DEF = 1000;
    localparam int CYCLES_PRESET_DEF = 1000;
    // one register access from the fieldbus slave logic
    typedef struct packed {
        logic wr;            // write strobe, one cycle
        logic rd;            // read strobe, one cycle
        logic [15:0] addr;   // word address
        logic [15:0] wdata;  // write data
    } alor_req_t;
    // read answer
    typedef struct packed {
        logic valid;         // one-cycle answer marker
        logic err;           // unmapped address
        logic [15:0] rdata;  // read data
    } alor_rsp_t;
endpackage

/* File: hdl/alor_alarm_latch.sv */
// file: one three-state latched limit alarm
`timescale 1ns/1ns
`default_nettype none
module alor_alarm_latch
    import alor_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic active,   // synchronised fault level
    input wire logic ack,      // acknowledge pulse
    output logic [1:0] state   // 0 none, 1 stored, 2 active
);
    // fault sets active, leaving sets stored, ack clears only stored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ALARM_NONE;
        else if (active)
            state <= ALARM_ACTIVE;
        else if (state == ALARM_ACTIVE)
            state <= ALARM_STORED;
        else if (ack)
            state <= ALARM_NONE;
    end
endmodule
`default_nettype wire

/* File: hdl/alor_top.sv */
// file: alarm latch, maintenance messages and switching output routing
`timescale 1ns/1ns
`default_nettype none
module alor_top
    import alor_pkg::*;
#(
    parameter int CNT_W = 32,                   // maintenance counter width
    parameter int HOURS_PRESET = HOURS_PRESET_DEF,
    parameter int CYCLES_PRESET = CYCLES_PRESET_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire alor_req_t req,          // register access, same clock domain
    output alor_rsp_t rsp,              // registered read answer
    input wire logic [2:0] limit_fault, // limit 1..3 exceeded, from pins
    input wire logic hour_tick,         // one pulse per operating hour, same domain
    output logic switch_out             // switching output, 1 = on
);
    // refuse presets the counters cannot hold
    initial
    begin
        // counter width and presets must be usable at all
        if (CNT_W < 2 || CNT_W > 32 || HOURS_PRESET < 1 || CYCLES_PRESET < 1)
            $error("alor_top: bad counter parameters");
        // a preset beyond the counter width would never be reached
        if (CNT_W < 32 && (HOURS_PRESET >= (1 << CNT_W) || CYCLES_PRESET >= (1 << CNT_W)))
            $error("alor_top: preset exceeds counter width");
    end

    // preset limits, cut on purpose to the counter width
    localparam logic [CNT_W-1:0] HOURS_LIM = CNT_W'(HOURS_PRESET);
    localparam logic [CNT_W-1:0] CYCLES_LIM = CNT_W'(CYCLES_PRESET);

    // internal state
    logic [2:0] fault_meta;      // first synchroniser stage
    logic [2:0] fault_sync;      // second stage, read by logic
    logic [2:0] enable;          // per-limit output enables
    logic sense;                 // output sense select
    logic [1:0] lim_state [2:0]; // latched status of limits 2 and 3 (index 1,2)
    logic [1:0] lim_ack;         // acknowledge pulses for limits 2, 3
    logic hours_msg;             // hours maintenance message
    logic cycles_msg;            // cycles maintenance message
    logic [CNT_W-1:0] hours_cnt; // operating hours this period
    logic [CNT_W-1:0] cycles_cnt;// switching cycles this period
    logic next_switch;           // routed output value

    // acknowledge decode: a write of the acknowledge value to one status word
    function automatic logic ack_hit(alor_req_t r, logic [15:0] a);
        return r.wr && (r.wdata == ACK_VALUE) && (r.addr == a);
    endfunction

    // slot 0 keeps the array indexed by limit number
    assign lim_state[0] = ALARM_NONE; // limit 1 status lives elsewhere

    // two-stage synchroniser for the fault pins
    // only the second stage feeds logic, so a metastable first stage never spreads
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // both stages start at no fault
            fault_meta <= 3'h0;
            fault_sync <= 3'h0;
        end
        else
        begin
            // shift the pin level in
            fault_meta <= limit_fault;
            fault_sync <= fault_meta;
        end
    end

    // latched alarms for limits 2 and 3
    // index 1 is limit two, index 2 is limit three
    genvar gi;
    generate
        for (gi = 1; gi < 3; gi++)
        begin : g_lim
            // acknowledge only when the matching status word is written with zero
            assign lim_ack[gi-1] = ack_hit(req, (gi == 1) ? ADDR_LIM2_STATE
                                                          : ADDR_LIM3_STATE);
            // one latch per limit
            alor_alarm_latch u_latch (
                .clk(clk),
                .rst_n(rst_n),
                .active(fault_sync[gi]),
                .ack(lim_ack[gi-1]),
                .state(lim_state[gi])
            );
        end
    endgenerate

    // output settings written from the bus
    // only bit 0 of each write is kept; other addresses leave settings alone
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // all routes off, direct sense
            enable <= ENABLE_RESET;
            sense <= SENSE_RESET;
        end
        else if (req.wr)
        begin
            case (req.addr)
                ADDR_LIM1_EN: enable[0] <= req.wdata[0];
                ADDR_LIM2_EN: enable[1] <= req.wdata[0];
                ADDR_LIM3_EN: enable[2] <= req.wdata[0];
                ADDR_SENSE: sense <= req.wdata[0];
                default: ;
            endcase
        end
    end

    // routing: OR of enabled active alarms, then sense
    // limit one routes on its synced level; its latched status lives elsewhere
    always_comb
    begin
        next_switch = |(enable & fault_sync);
        // inverse sense turns an active route off
        if (sense == SENSE_INVERSE)
            next_switch = !next_switch;
    end

    // switching output flop
    // reset value equals the routed value with all enables off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            switch_out <= SENSE_RESET;
        else
            switch_out <= next_switch;
    end

    // operating hours counter and its message
    // an ack counts only while the message is up; counting has stopped then,
    // so setting and clearing the message can never fall in one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // new period, no message
            hours_cnt <= '0;
            hours_msg <= 1'b0;
        end
        else if (hours_msg && ack_hit(req, ADDR_HOURS_MSG))
        begin
            // acknowledge: clear message and start a new period
            hours_cnt <= '0;
            hours_msg <= 1'b0;
        end
        else if (hour_tick && hours_cnt < HOURS_LIM)
        begin
            // count until the preset is reached, then hold
            hours_cnt <= hours_cnt + 1'b1;
            if (hours_cnt + 1'b1 == HOURS_LIM)
                hours_msg <= 1'b1;
        end
    end

    // switching cycle counter: counts off-to-on transitions of the output
    // counting stops at the preset until acknowledged
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // new period, no message
            cycles_cnt <= '0;
            cycles_msg <= 1'b0;
        end
        else if (cycles_msg && ack_hit(req, ADDR_CYCLES_MSG))
        begin
            // acknowledge: clear message and zero the period count
            cycles_cnt <= '0;
            cycles_msg <= 1'b0;
        end
        else if (next_switch && !switch_out && cycles_cnt < CYCLES_LIM)
        begin
            // one more off-to-on change of the output
            cycles_cnt <= cycles_cnt + 1'b1;
            if (cycles_cnt + 1'b1 == CYCLES_LIM)
                cycles_msg <= 1'b1;
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rsp <= '0;
        else
        begin
            // answer fields fall back to zero when no read is pending
            rsp.valid <= req.rd;
            rsp.err <= 1'b0;
            rsp.rdata <= 16'h0000;
            if (req.rd)
            begin
                // status words return their code in the low bits
                case (req.addr)
                    ADDR_LIM2_STATE: rsp.rdata <= {14'h0000, lim_state[1]};
                    ADDR_LIM3_STATE: rsp.rdata <= {14'h0000, lim_state[2]};
                    ADDR_HOURS_MSG: rsp.rdata <= {15'h0000, hours_msg};
                    ADDR_CYCLES_MSG: rsp.rdata <= {15'h0000, cycles_msg};
                    ADDR_OUT_STATE: rsp.rdata <= {15'h0000, switch_out};
                    ADDR_SENSE: rsp.rdata <= {15'h0000, sense};
                    ADDR_LIM1_EN: rsp.rdata <= {15'h0000, enable[0]};
                    ADDR_LIM2_EN: rsp.rdata <= {15'h0000, enable[1]};
                    ADDR_LIM3_EN: rsp.rdata <= {15'h0000, enable[2]};
                    default: rsp.err <= 1'b1; // unmapped word
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/alor_monitor.sv */
// checker: register answer timing and read-back relations
`timescale 1ns/1ns
`default_nettype none
module alor_monitor
    import alor_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire alor_req_t req,
    input wire alor_rsp_t rsp,
    input wire logic [2:0] limit_fault,
    input wire logic hour_tick,
    input wire logic switch_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // read or write request to one address
    sequence s_rd(a);
        req.rd && req.addr == a;
    endsequence
    sequence s_wr(a);
        req.wr && req.addr == a;
    endsequence
    // fault held through the synchroniser, then read
    sequence s_held(b, a);
        limit_fault[b] [*4] ##0 s_rd(a);
    endsequence
    a_read_answer: assert property (req.rd |=> rsp.valid)
        else $error("read not answered next cycle");
    a_no_answer: assert property (!req.rd |=> !rsp.valid)
        else $error("answer without read");
    a_rdata_idle: assert property (!rsp.valid |-> rsp.rdata == 16'h0 && !rsp.err)
        else $error("answer fields not idle");
    a_out_read: assert property (s_rd(ADDR_OUT_STATE) |=>
        rsp.rdata == {15'h0, $past(switch_out)})
        else $error("output state read wrong");
    a_unmapped_err: assert property (s_rd(16'h0000) |=> rsp.err)
        else $error("unmapped read not flagged");
    a_lim2_active: assert property (s_held(1, ADDR_LIM2_STATE) |=>
        rsp.rdata == {14'h0, ALARM_ACTIVE})
        else $error("limit two not active");
    a_lim3_active: assert property (s_held(2, ADDR_LIM3_STATE) |=>
        rsp.rdata == {14'h0, ALARM_ACTIVE})
        else $error("limit three not active");
    a_sense_back: assert property (s_wr(ADDR_SENSE) ##2 s_rd(ADDR_SENSE) |=>
        rsp.rdata[0] == $past(req.wdata[0], 3))
        else $error("sense read-back wrong");
endmodule
bind alor_top alor_monitor u_alor_monitor (.clk(clk), .rst_n(rst_n), .req(req),
    .rsp(rsp), .limit_fault(limit_fault), .hour_tick(hour_tick), .switch_out(switch_out));
`default_nettype wire

/* File: test/alor_master.sv */
// partner: fieldbus master making single-word register accesses
`timescale 1ns/1ns
`default_nettype none
module alor_master
    import alor_pkg::*;
(
    input wire logic clk,
    output var alor_req_t req
);
    initial req = '{1'b0, 1'b0, 16'hffff, 16'hffff};
    // strobe one cycle, then release lines to inverted values
    task automatic access(logic w, logic [15:0] a, logic [15:0] d);
        @(negedge clk);
        req <= '{w, !w, a, d};
        @(negedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        access(1'b1, a, d);
    endtask
    task automatic rd(logic [15:0] a);
        access(1'b0, a, 16'h0);
    endtask
endmodule
`default_nettype wire

/* File: test/test_alarm_latch_output_routing.sv */
// testbench: register map, alarm latching, maintenance and output routing
`timescale 1ns/1ns
`default_nettype none
module test_alarm_latch_output_routing
    import alor_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] limit_fault = 3'h0;
    logic hour_tick = 1'b0;
    wire alor_req_t req;
    wire alor_rsp_t rsp;
    wire logic switch_out;
    logic [16:0] exp_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [2:0] en;
    logic sv;
    logic [15:0] la;
    always #50 clk = ~clk;
    alor_top #(.HOURS_PRESET(3), .CYCLES_PRESET(3)) u_alor_top (.clk(clk),
        .rst_n(rst_n), .req(req), .rsp(rsp), .limit_fault(limit_fault),
        .hour_tick(hour_tick), .switch_out(switch_out));
    alor_master u_alor_master (.clk(clk), .req(req));
    task automatic check(string nm, logic [16:0] seen, logic [16:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, want, seen);
        end
    endtask
    // note the expected answer, then read
    task automatic rd(logic [15:0] a, logic [16:0] e);
        exp_q.push_back(e);
        u_alor_master.rd(a);
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        u_alor_master.wr(a, d);
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    // answers compared against oldest note
    always @(negedge clk)
        if (rsp.valid === 1'b1)
            check("read answer", {rsp.err, rsp.rdata}, exp_q.pop_front());
    task automatic finish_test();
        check("pending notes", 17'(exp_q.size()), 17'h0);
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #(5000 * 100);
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h4cd2));
        cyc(5);
        rst_n = 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            rd(ADDR_LIM2_STATE + 16'(j), 17'h0);
            rd(ADDR_SENSE + 16'(j), 17'h0);
        end
        wr(ADDR_OUT_STATE, 16'h1);
        rd(ADDR_OUT_STATE, 17'h0);
        rd(16'h0000, 17'h10000);
        $display("test reset values done");
        wr(ADDR_LIM1_EN, 16'h1);
        for (int k = 1; k <= 6; k++)
        begin
            limit_fault = 3'h1;
            hour_tick = 1'b1;
            cyc(1);
            hour_tick = 1'b0;
            cyc(4);
            limit_fault = 3'h0;
            cyc(5);
            rd(ADDR_HOURS_MSG, 17'(k % 3 == 0));
            rd(ADDR_CYCLES_MSG, 17'(k % 3 == 0));
            if (k == 3)
            begin
                wr(ADDR_HOURS_MSG, ACK_VALUE);
                wr(ADDR_CYCLES_MSG, ACK_VALUE);
            end
        end
        $display("test maintenance done");
        for (int i = 1; i <= 2; i++)
        begin
            la = ADDR_LIM2_STATE + 16'(i - 1);
            limit_fault = 3'h1 << i;
            cyc(5);
            rd(la, 17'h2);
            wr(la, ACK_VALUE);
            rd(la, 17'h2);
            limit_fault = 3'h0;
            cyc(5);
            rd(la, 17'h1);
            wr(la, 16'h5);
            rd(la, 17'h1);
            wr(la, ACK_VALUE);
            rd(la, 17'h0);
        end
        $display("test alarm latch done");
        for (int k = 0; k < 12; k++)
        begin
            en = 3'($urandom);
            sv = 1'($urandom);
            for (int j = 0; j < 3; j++)
                wr(ADDR_LIM1_EN + 16'(j), {15'h0, en[j]});
            wr(ADDR_SENSE, {15'h0, sv});
            rd(ADDR_SENSE, 17'(sv));
            limit_fault = 3'($urandom);
            cyc(5);
            check("switch_out", 17'(switch_out), 17'((|(en & limit_fault)) ^ sv));
            rd(ADDR_OUT_STATE, 17'((|(en & limit_fault)) ^ sv));
        end
        cyc(3);
        $display("test output routing done");
        finish_test();
    end
endmodule
`default_nettype wire
